// file: src/id_filter_pkg.sv
package id_filter_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_TAG1 = 8'hBC;
  localparam logic [7:0] ADDR_TAG2 = 8'hBD;
  localparam logic [7:0] ADDR_TAG3 = 8'hBE;
  localparam logic [7:0] ADDR_TAG4 = 8'hBF;
  localparam logic [7:0] ADDR_MASK1 = 8'hC4;
  localparam int STD_ID_W = 11;
  localparam int EXT_ID_W = 29;
  localparam int TAG2_STD_LSB = 5;
  localparam int TAG4_ID_LSB = 3;
  localparam int BIT_RTR = 2;
  localparam int BIT_RB1 = 1;
  localparam int BIT_RB0 = 0;
  localparam logic [7:0] RSVD_READ = 8'h00;
endpackage : id_filter_pkg

// file: src/id_match_if.sv
`timescale 1ns/10ps
`default_nettype none
interface id_match_if;
  logic [28:0] tag_id;
  logic [28:0] cmp_en;
  logic tag_rtr;
  logic tag_ext;
  logic [28:0] rx_id;
  logic rx_rtr;
  logic rx_ext;
  logic hit;
  modport owner (output tag_id, cmp_en, tag_rtr, tag_ext, rx_id, rx_rtr,
    rx_ext, input hit);
  modport cmp (input tag_id, cmp_en, tag_rtr, tag_ext, rx_id, rx_rtr,
    rx_ext, output hit);
endinterface : id_match_if
`default_nettype wire

// file: src/id_compare.sv
`timescale 1ns/10ps
`default_nettype none
module id_compare (
  id_match_if.cmp m
);
  wire [28:0] diff;
  // Clear enable forces bit true
  assign diff = (m.tag_id ^ m.rx_id) & m.cmp_en;
  // Format and rtr always compared in this block
  assign m.hit = (diff == 29'h0000000) && (m.tag_rtr == m.rx_rtr) &&
    (m.tag_ext == m.rx_ext);
endmodule : id_compare
`default_nettype wire

// file: src/can_msg_obj_id_tag_mask.sv
// Function
// - Standard layout keeps id bits 10..3 in tag 1 bits 7..0.
// - Standard layout keeps id bits 2..0 in tag 2 bits 7..5.
// - Reserved bits read undefined and software writes them as zero.
// - Standard layout tag 3 holds no identifier bits.
// - Standard tag 4 holds rtr tag in bit 2 and rb0 tag in bit 0.
// - Extended layout keeps id bits 28..21 in tag 1.
// - Extended layout keeps id bits 20..13 in tag 2.
// - Extended layout keeps id bits 12..5 in tag 3.
// - Extended tag 4 holds id 4..0, rtr, rb1 and rb0 tags.
// - Standard mask 1 holds compare enables for id bits 10..3.
// - Tags and mask have no reset value and software loads them.
// - A zero mask bit forces that compare true.
// - The extended format select picks the register layout.
// - Masking applies to reception only; transmit sends raw tag.
`timescale 1ns/10ps
`default_nettype none
module can_msg_obj_id_tag_mask
  import id_filter_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [DATA_W-1:0] sfr_wdata,
  output logic [DATA_W-1:0] sfr_rdata,
  input wire logic extended_format_select,
  input wire logic rx_check,
  input wire logic [28:0] rx_id,
  input wire logic rx_rtr,
  input wire logic rx_ext,
  output logic rx_hit,
  output logic [28:0] tx_id,
  output logic tx_rtr,
  output logic tx_rb1,
  output logic tx_rb0
);
  // Raw byte storage; layout is only a view chosen by format select
  logic [7:0] tag1_reg, tag2_reg, tag3_reg, tag4_reg, mask1_reg;
  logic [7:0] rdata_next;
  logic hit_reg;
  logic [28:0] tx_id_reg;
  logic tx_rtr_reg, tx_rb1_reg, tx_rb0_reg;

  // Fill patterns for unused id bits, enables outside mask 1, reserved read bits and a zero id
  localparam logic [17:0] STD_PAD = 18'h00000;
  localparam logic [20:0] EXT_LOW_EN = 21'h1FFFFF;
  localparam logic [2:0] STD_LOW_EN = 3'h7;
  localparam logic [4:0] RSVD5 = 5'h00;
  localparam logic [28:0] ID_ZERO = 29'h0000000;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction : addr_is

  wire wr_tag1 = sfr_wr && addr_is(sfr_addr, ADDR_TAG1);
  wire wr_tag2 = sfr_wr && addr_is(sfr_addr, ADDR_TAG2);
  wire wr_tag3 = sfr_wr && addr_is(sfr_addr, ADDR_TAG3);
  wire wr_tag4 = sfr_wr && addr_is(sfr_addr, ADDR_TAG4);
  wire wr_mask1 = sfr_wr && addr_is(sfr_addr, ADDR_MASK1);

  // No reset on storage: contents undefined until software loads them
  always_ff @(posedge mclk) begin
    if (wr_tag1) tag1_reg <= sfr_wdata;
    if (wr_tag2) tag2_reg <= sfr_wdata;
    if (wr_tag3) tag3_reg <= sfr_wdata;
    if (wr_tag4) tag4_reg <= sfr_wdata;
    if (wr_mask1) mask1_reg <= sfr_wdata;
  end

  // Standard view: 11-bit id
  wire [10:0] std_id = {tag1_reg, tag2_reg[7:TAG2_STD_LSB]};
  // Extended view: 29-bit id
  wire [28:0] ext_id = {tag1_reg, tag2_reg, tag3_reg,
    tag4_reg[7:TAG4_ID_LSB]};
  wire [28:0] sel_id = extended_format_select ? ext_id :
    {STD_PAD, std_id};
  // Only mask 1 lives here; remaining enables treated as compare on, except standard id bits 28..11 which are off
  wire [28:0] sel_en = extended_format_select ?
    {mask1_reg, EXT_LOW_EN} :
    {STD_PAD, mask1_reg, STD_LOW_EN};

  // Reserved bits read as zero, a legal undefined value
  wire [7:0] rd_tag2 = extended_format_select ? tag2_reg :
    {tag2_reg[7:TAG2_STD_LSB], RSVD5};
  wire [7:0] rd_tag3 = extended_format_select ? tag3_reg : RSVD_READ;
  wire [7:0] rd_tag4 = extended_format_select ? tag4_reg :
    {RSVD5, tag4_reg[BIT_RTR], 1'b0, tag4_reg[BIT_RB0]};

  always_comb begin
    case (sfr_addr)
      ADDR_TAG1: rdata_next = tag1_reg;
      ADDR_TAG2: rdata_next = rd_tag2;
      ADDR_TAG3: rdata_next = rd_tag3;
      ADDR_TAG4: rdata_next = rd_tag4;
      ADDR_MASK1: rdata_next = mask1_reg;
      default: rdata_next = RSVD_READ;
    endcase
  end

  id_match_if mi ();
  assign mi.tag_id = sel_id;
  assign mi.cmp_en = sel_en;
  assign mi.tag_rtr = tag4_reg[BIT_RTR];
  assign mi.tag_ext = extended_format_select;
  assign mi.rx_id = rx_id;
  assign mi.rx_rtr = rx_rtr;
  assign mi.rx_ext = rx_ext;
  id_compare u_cmp (.m(mi));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
      hit_reg <= 1'b0;
      tx_id_reg <= ID_ZERO;
      tx_rtr_reg <= 1'b0;
      tx_rb1_reg <= 1'b0;
      tx_rb0_reg <= 1'b0;
    end else begin
      if (sfr_rd) sfr_rdata <= rdata_next;
      hit_reg <= rx_check && mi.hit;
      tx_id_reg <= sel_id;
      tx_rtr_reg <= tag4_reg[BIT_RTR];
      tx_rb1_reg <= extended_format_select && tag4_reg[BIT_RB1];
      tx_rb0_reg <= tag4_reg[BIT_RB0];
    end
  end

  assign rx_hit = hit_reg;
  assign tx_id = tx_id_reg;
  assign tx_rtr = tx_rtr_reg;
  assign tx_rb1 = tx_rb1_reg;
  assign tx_rb0 = tx_rb0_reg;

  // Request qualifiers shared by the checks below
  wire rd_std = sfr_rd && !extended_format_select;
  wire rd_ext = sfr_rd && extended_format_select;
  wire chk_std = rx_check && !extended_format_select;
  wire chk_ext = rx_check && extended_format_select;
  wire [28:0] en_diff = (rx_id ^ sel_id) & sel_en;
  wire meta_same = (rx_rtr == tag4_reg[BIT_RTR]) &&
    (rx_ext == extended_format_select);

  // Write in one cycle, read the same address in the next
  sequence wr_rd_s(logic [ADDR_W-1:0] a);
    (sfr_wr && addr_is(sfr_addr, a)) ##1 (sfr_rd && addr_is(sfr_addr, a));
  endsequence : wr_rd_s

  // A frame that differs from the tag in a compare-enabled id bit
  sequence id_miss_s;
    rx_check && (en_diff != ID_ZERO);
  endsequence : id_miss_s

  hit_needs_check_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      rx_hit |-> $past(rx_check))
    else $error("hit without check");

  tx_unmasked_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      $past(extended_format_select)
      |-> tx_id == $past(ext_id))
    else $error("tx id masked");

  std_rsvd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_std && addr_is(sfr_addr, ADDR_TAG3))
      |=> sfr_rdata == RSVD_READ)
    else $error("tag3 not reserved");

  std_tx_high_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      !$past(extended_format_select)
      |-> tx_id[28:STD_ID_W] == STD_PAD)
    else $error("std id too wide");

  tag1_read_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      wr_rd_s(ADDR_TAG1)
      |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("tag1 lost");

  mask1_read_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      wr_rd_s(ADDR_MASK1)
      |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mask1 lost");

  tag4_std_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_std && addr_is(sfr_addr, ADDR_TAG4))
      |=> sfr_rdata[7:TAG4_ID_LSB] == RSVD5 && !sfr_rdata[BIT_RB1])
    else $error("tag4 rsvd");

  tag4_std_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_std && addr_is(sfr_addr, ADDR_TAG4))
      |=> sfr_rdata[BIT_RTR] == $past(tag4_reg[BIT_RTR]) &&
      sfr_rdata[BIT_RB0] == $past(tag4_reg[BIT_RB0]))
    else $error("tag4 std fields lost");

  tag1_std_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_std && addr_is(sfr_addr, ADDR_TAG1))
      |=> sfr_rdata == $past(tag1_reg))
    else $error("tag1 std read");

  tag2_std_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_std && addr_is(sfr_addr, ADDR_TAG2))
      |=> sfr_rdata[7:TAG2_STD_LSB] == $past(tag2_reg[7:TAG2_STD_LSB]))
    else $error("tag2 std read");

  tag2_rsvd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_std && addr_is(sfr_addr, ADDR_TAG2))
      |=> sfr_rdata[TAG2_STD_LSB-1:0] == RSVD5)
    else $error("tag2 rsvd");

  tag1_ext_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_ext && addr_is(sfr_addr, ADDR_TAG1))
      |=> sfr_rdata == $past(tag1_reg))
    else $error("tag1 ext read");

  tag2_ext_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_ext && addr_is(sfr_addr, ADDR_TAG2))
      |=> sfr_rdata == $past(tag2_reg))
    else $error("tag2 ext read");

  tag3_ext_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_ext && addr_is(sfr_addr, ADDR_TAG3))
      |=> sfr_rdata == $past(tag3_reg))
    else $error("tag3 ext read");

  tag4_ext_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rd_ext && addr_is(sfr_addr, ADDR_TAG4))
      |=> sfr_rdata == $past(tag4_reg))
    else $error("tag4 ext read");

  mask1_rd_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (sfr_rd && addr_is(sfr_addr, ADDR_MASK1))
      |=> sfr_rdata == $past(mask1_reg))
    else $error("mask1 read");

  std_view_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      chk_std
      |=> tx_id == {STD_PAD, $past(std_id)})
    else $error("std tx view");

  tx_meta_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      rx_check
      |=> tx_rtr == $past(tag4_reg[BIT_RTR]) &&
      tx_rb0 == $past(tag4_reg[BIT_RB0]))
    else $error("tx tag bits");

  std_rb1_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      chk_std
      |=> !tx_rb1)
    else $error("std rb1 sent");

  ext_rb1_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      chk_ext
      |=> tx_rb1 == $past(tag4_reg[BIT_RB1]))
    else $error("ext rb1 lost");

  exact_hit_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rx_check && rx_id == sel_id && meta_same)
      |=> rx_hit)
    else $error("exact frame missed");

  masked_hit_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rx_check && en_diff == ID_ZERO && meta_same)
      |=> rx_hit)
    else $error("masked frame missed");

  id_miss_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      id_miss_s
      |=> !rx_hit)
    else $error("enabled bit ignored");

  rtr_miss_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rx_check && rx_rtr != tag4_reg[BIT_RTR])
      |=> !rx_hit)
    else $error("rtr mismatch hit");

  hit_pulse_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      !rx_check
      |=> !rx_hit)
    else $error("hit without frame");

  ext_no_hit_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (rx_check && rx_ext != extended_format_select)
      |=> !rx_hit)
    else $error("format mismatch hit");

  mask_free_a:
    assert property (@(posedge mclk) disable iff (!resetn)
      (chk_std && !rx_ext && mask1_reg == 8'h00 &&
      rx_rtr == tag4_reg[BIT_RTR] && rx_id[28:STD_ID_W] == STD_PAD &&
      rx_id[2:0] == tag2_reg[7:TAG2_STD_LSB])
      |=> rx_hit)
    else $error("mask ignored");
endmodule : can_msg_obj_id_tag_mask
`default_nettype wire

// file: testbench/frame_source.sv
`timescale 1ns/10ps
`default_nettype none
module frame_source (
  input wire logic mclk,
  output logic rx_check,
  output logic [28:0] rx_id,
  output logic rx_rtr,
  output logic rx_ext
);
  initial begin
    rx_check = 1'b0;
    rx_id = 29'h0;
    rx_rtr = 1'b0;
    rx_ext = 1'b0;
  end
  // Fields inverted after each frame so stale values never pass as a match
  task automatic send(input logic [28:0] id, input logic rtr,
    input logic ext);
    @(negedge mclk);
    rx_id = id;
    rx_rtr = rtr;
    rx_ext = ext;
    rx_check = 1'b1;
    @(negedge mclk);
    rx_check = 1'b0;
    rx_id = ~id;
    rx_rtr = ~rtr;
    rx_ext = ~ext;
  endtask : send
endmodule : frame_source
`default_nettype wire

// file: testbench/can_msg_obj_id_tag_mask_test.sv
`timescale 1ns/10ps
`default_nettype none
module can_msg_obj_id_tag_mask_test;
  import id_filter_pkg::*;
  logic mclk, resetn, sfr_wr, sfr_rd, extended_format_select;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic rx_check, rx_rtr, rx_ext, rx_hit, tx_rtr, tx_rb1, tx_rb0;
  logic [28:0] rx_id, tx_id;
  int num_errors, check_count;
  can_msg_obj_id_tag_mask can_msg_obj_id_tag_mask_i (.mclk, .resetn,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .extended_format_select, .rx_check, .rx_id, .rx_rtr, .rx_ext,
    .rx_hit, .tx_id, .tx_rtr, .tx_rb1, .tx_rb0);
  frame_source frame_source_i (.mclk, .rx_check, .rx_id, .rx_rtr, .rx_ext);
  task automatic chk(input logic [28:0] got, input logic [28:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, d);
  endtask : wr_rd
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
  endtask : rd
  task automatic frm(input logic [28:0] id, input logic rtr, ext, hit);
    frame_source_i.send(id, rtr, ext);
    chk(rx_hit, hit);
  endtask : frm
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
  initial begin
    {resetn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 19'h0;
    extended_format_select = 1'b0;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    wr_rd(ADDR_TAG1, 8'hA5);
    wr(ADDR_TAG2, 8'hE0);
    wr(ADDR_TAG3, 8'h00);
    wr(ADDR_TAG4, 8'h05);
    wr_rd(ADDR_MASK1, 8'hF0);
    wr(8'hC0, 8'hFF);
    rd(ADDR_TAG1, 8'hA5);
    rd(ADDR_TAG2, 8'hE0);
    rd(ADDR_TAG3, RSVD_READ);
    rd(ADDR_TAG4, 8'h05);
    rd(ADDR_MASK1, 8'hF0);
    rd(8'hC0, 8'h00);
    chk(tx_id, 29'h52F);
    chk({tx_rtr, tx_rb0}, 2'b11);
    frm(29'h557, 1'b1, 1'b0, 1'b1);
    frm(29'h12F, 1'b1, 1'b0, 1'b0);
    frm(29'h52F, 1'b0, 1'b0, 1'b0);
    frm(29'h52F, 1'b1, 1'b1, 1'b0);
    frm(29'h52F, 1'b1, 1'b0, 1'b1);
    wr(ADDR_MASK1, 8'h00);
    frm(29'h00F, 1'b1, 1'b0, 1'b1);
    extended_format_select = 1'b1;
    wr(ADDR_TAG1, 8'h12);
    wr(ADDR_TAG2, 8'h34);
    wr(ADDR_TAG3, 8'h56);
    wr(ADDR_TAG4, 8'h7B);
    wr(ADDR_MASK1, 8'h00);
    rd(ADDR_TAG1, 8'h12);
    rd(ADDR_TAG2, 8'h34);
    rd(ADDR_TAG3, 8'h56);
    rd(ADDR_TAG4, 8'h7B);
    chk(tx_id, 29'h2468ACF);
    chk({tx_rtr, tx_rb1, tx_rb0}, 3'b011);
    frm(29'h1DA68ACF, 1'b0, 1'b1, 1'b1);
    frm(29'h2468ACE, 1'b0, 1'b1, 1'b0);
    frm(29'h2468ACF, 1'b1, 1'b1, 1'b0);
    frm(29'h2468ACF, 1'b0, 1'b0, 1'b0);
    complete_run;
  end
endmodule : can_msg_obj_id_tag_mask_test
`default_nettype wire
